// >>> core/ttic_core.v
// Time tag, INL correction, event framing, control register and front-panel indicators
// Function
// R1 - Extra word: tag upper 27 bits
// R2 - Trailer slot field carries tag low bits
// R3 - Tag words off at reset; bits 9,11
// R4 - Free 32-bit counter latched on trigger
// R5 - Per-period table, subtract entry per bin
// R6 - 200 ps: 128 entries, low 7 bits
// R7 - 100 ps: 256 entries, low 8 bits
// R8 - 800 ps: hits pass unchanged
// R9 - Bit 5 enables correction, set at reset
// R10 - Table contents loaded from flash
// R11 - Two trigger inputs ORed together
// R12 - Triggers rising, 25 ns wide, 75 ns apart
// R13 - Clear input active high, 25 ns
// R14 - Count reset rising edge, 25 ns
// R15 - Clock internal or external by switch
// R16 - Access indicator on every bus cycle
// R17 - Full indicator when buffer full
// R18 - Error indicator during global error
// R19 - Data-ready when event or datum held
// R20 - Configuration lights three indicators together
// R21 - Hits corrected before entering buffer
`include "ttic_regs.vh"
module ttic_core #(
   parameter HIT_W       = 21,
   parameter CONFIG_CYC  = `TTIC_CONFIG_CYCLES,
   parameter [4:0] SLOT  = 5'h00
) (
   // Clock and reset (clock already selected by the source switch)
   input  wire             CLOCK,
   input  wire             ARST_N,
   // Register port: one 16-bit control register
   input  wire             REG_SEL,
   input  wire             REG_WR,
   input  wire [15:0]      REG_ADDR,
   input  wire [15:0]      REG_WDATA,
   output reg  [15:0]      REG_RDATA,
   // Front-panel control inputs (asynchronous)
   input  wire             TRIG_PANEL,
   input  wire             TRIG_CONN,
   input  wire             HARDWARE_CLEAR_INPUT,
   input  wire             COUNT_RESET_INPUT,
   input  wire             GLOBAL_ERROR,
   // Setup inputs
   input  wire [1:0]       RESOLUTION,
   input  wire             EVENT_MODE,
   // Flash table loader
   input  wire             FLASH_WE,
   input  wire             FLASH_SEL_100PS,
   input  wire [7:0]       FLASH_IDX,
   input  wire [7:0]       FLASH_VAL,
   // Hit stream from converter chips
   input  wire             HIT_VALID,
   output reg              HIT_READY,
   input  wire [HIT_W-1:0] HIT_TIME,
   input  wire             EVT_END,
   // Event word stream toward the output buffer
   output reg              WORD_VALID,
   input  wire             WORD_READY,
   output reg  [31:0]      WORD_DATA,
   input  wire             OUTBUF_FULL,
   input  wire [15:0]      OUTBUF_EVENTS,
   input  wire [15:0]      OUTBUF_WORDS,
   // Indicators
   output reg              ACCESS_INDICATOR,
   output reg              FULL_INDICATOR,
   output reg              ERROR_INDICATOR,
   output reg              DATA_READY_INDICATOR,
   output reg              TRIGGER_OUT,
   output reg              CLEAR_OUT,
   output reg              COUNT_RESET_OUT
);
   localparam ST_IDLE = 2'h0;
   localparam ST_HITS = 2'h1;
   localparam ST_TAG  = 2'h2;
   localparam ST_TRL  = 2'h3;

   // Rising edge of a synchronised level
   function rise;
      input cur;
      input prev;
      begin
         rise = cur && !prev;
      end
   endfunction

   reg  [15:0] ctrl_q;
   reg  [2:0]  trg_s_q, clr_s_q, count_reset_input_s_q, err_s_q;
   reg  [31:0] tag_cnt_q;
   reg  [31:0] tag_lat_q;
   reg  [11:0] evt_id_q;
   reg  [1:0]  state_q;
   reg  [31:0] cfg_cnt_q;
   reg  [2:0]  acc_cnt_q;
   reg         pend_q;
   reg         last_q;
   reg         hit_v_q;
   reg  [HIT_W-1:0] hit_raw_q;
   reg  [1:0]  hit_res_q;
   reg  [11:0] word_cnt_q;
   wire [7:0]  lut200_val;
   wire [7:0]  lut100_val;
   wire        buf_in_ready;
   wire        buf_full;
   wire        buf_out_valid;
   wire [31:0] buf_out_data;
   reg  [31:0] enq_data;
   reg         enq_valid;
   reg  [HIT_W-1:0] corr;
   wire        trg_edge  = rise(trg_s_q[1], trg_s_q[2]);
   wire        count_reset_input_edge = rise(count_reset_input_s_q[1], count_reset_input_s_q[2]);
   wire        hit_take  = HIT_VALID && HIT_READY;
   wire        tag_en    = ((ctrl_q & `TTIC_CTRL_TAG_MASK) == `TTIC_CTRL_TAG_MASK); // R3
   wire        inl_en    = ctrl_q[`TTIC_CTRL_INL_EN_BIT]; // R9
   wire        ctrl_hit  = REG_SEL && (REG_ADDR == `TTIC_CTRL_OFFSET);
   wire        configuring = (cfg_cnt_q != 32'h0000_0000);

   // Input synchronisers; stage 0 feeds only stage 1
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         trg_s_q  <= 3'h0;
         clr_s_q  <= 3'h0;
         count_reset_input_s_q <= 3'h0;
         err_s_q  <= 3'h0;
      end else begin
         trg_s_q  <= {trg_s_q[1:0], TRIG_PANEL | TRIG_CONN}; // R11 R12
         clr_s_q  <= {clr_s_q[1:0], HARDWARE_CLEAR_INPUT}; // R13
         count_reset_input_s_q <= {count_reset_input_s_q[1:0], COUNT_RESET_INPUT}; // R14
         err_s_q  <= {err_s_q[1:0], GLOBAL_ERROR};
      end
   end

   // Control register; bit 5 set at reset, tag bits clear
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_q    <= `TTIC_CTRL_RESET; // R3 R9
         REG_RDATA <= 16'h0000;
      end else begin
         if (ctrl_hit && REG_WR) begin
            ctrl_q <= REG_WDATA;
         end
         REG_RDATA <= ctrl_hit ? ctrl_q : 16'h0000;
      end
   end

   // Free-running tag counter; one tick per cycle of the selected clock.
   // Runs on CLOCK, so the 50 MHz rate holds when CLOCK is the 50 MHz source.
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         tag_cnt_q <= 32'h0000_0000;
         tag_lat_q <= 32'h0000_0000;
      end else begin
         tag_cnt_q <= tag_cnt_q + 32'h0000_0001; // R4 R15
         if (trg_edge) begin
            tag_lat_q <= tag_cnt_q; // R4
         end
      end
   end

   // Correction tables, one per compensated resolution
   ttic_inl_lut #(.ENTRIES(128), .IDX_W(7), .VAL_W(8)) u_lut200 (
      .clk     (CLOCK),
      .arst_n  (ARST_N),
      .load_we (FLASH_WE && !FLASH_SEL_100PS), // R10
      .load_idx(FLASH_IDX[6:0]),
      .load_val(FLASH_VAL),
      .rd_idx  (hit_take ? HIT_TIME[6:0] : hit_raw_q[6:0]), // R6
      .rd_val  (lut200_val)
   );
   ttic_inl_lut #(.ENTRIES(256), .IDX_W(8), .VAL_W(8)) u_lut100 (
      .clk     (CLOCK),
      .arst_n  (ARST_N),
      .load_we (FLASH_WE && FLASH_SEL_100PS), // R10
      .load_idx(FLASH_IDX),
      .load_val(FLASH_VAL),
      .rd_idx  (hit_take ? HIT_TIME[7:0] : hit_raw_q[7:0]), // R7
      .rd_val  (lut100_val)
   );

   // Corrected hit; table entries are signed rounded errors
   always @* begin
      corr = hit_raw_q;
      if (inl_en && hit_res_q == `TTIC_RES_200PS) begin
         corr = hit_raw_q - {{(HIT_W-8){lut200_val[7]}}, lut200_val}; // R5 R6
      end else if (inl_en && hit_res_q == `TTIC_RES_100PS) begin
         corr = hit_raw_q - {{(HIT_W-8){lut100_val[7]}}, lut100_val}; // R5 R7
      end
   end

   // Word to enqueue this cycle, correction applied before the buffer
   always @* begin
      enq_valid = 1'b0;
      enq_data  = 32'h0000_0000;
      case (state_q)
         ST_HITS: begin
            enq_valid = hit_v_q;
            enq_data  = {11'h000, corr}; // R21 R8
         end
         ST_TAG: begin
            enq_valid = 1'b1;
            enq_data  = {`TTIC_TAG_WORD_ID, tag_lat_q[31:5]}; // R1
         end
         ST_TRL: begin
            enq_valid = 1'b1;
            enq_data  = {`TTIC_TRAILER_ID, (tag_en ? tag_lat_q[4:0] : SLOT), 10'h000, word_cnt_q}; // R2
         end
         default: begin
            enq_valid = 1'b0;
            enq_data  = 32'h0000_0000;
         end
      endcase
   end

   // Event framing: hits, optional tag word, trailer
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_q    <= ST_IDLE;
         evt_id_q   <= 12'h000;
         pend_q     <= 1'b0;
         hit_v_q    <= 1'b0;
         hit_raw_q  <= {HIT_W{1'b0}};
         hit_res_q  <= `TTIC_RES_800PS;
         last_q     <= 1'b0;
         word_cnt_q <= 12'h000;
         HIT_READY  <= 1'b0;
      end else if (clr_s_q[1]) begin
         state_q    <= ST_IDLE;
         pend_q     <= 1'b0;
         hit_v_q    <= 1'b0;
         word_cnt_q <= 12'h000;
         HIT_READY  <= 1'b0;
      end else begin
         if (count_reset_input_edge) begin
            evt_id_q <= 12'h000;
         end
         case (state_q)
            ST_IDLE: begin
               if (trg_edge || pend_q) begin
                  pend_q     <= 1'b0;
                  word_cnt_q <= 12'h000;
                  HIT_READY  <= 1'b1;
                  state_q    <= ST_HITS;
               end
            end
            ST_HITS: begin
               if (trg_edge) begin
                  pend_q <= 1'b1;
               end
               // One hit in flight, so a stalled buffer never drops a taken hit
               if (hit_take) begin
                  hit_v_q   <= 1'b1;
                  hit_raw_q <= HIT_TIME;
                  hit_res_q <= RESOLUTION;
                  last_q    <= EVT_END;
                  HIT_READY <= 1'b0;
               end else if (hit_v_q && buf_in_ready) begin
                  hit_v_q    <= 1'b0;
                  word_cnt_q <= word_cnt_q + 12'h001;
                  HIT_READY  <= !last_q;
               end else if (!HIT_READY && !hit_v_q) begin
                  state_q <= tag_en ? ST_TAG : ST_TRL; // R1 R3
               end
            end
            ST_TAG: begin
               if (trg_edge) begin
                  pend_q <= 1'b1;
               end
               if (buf_in_ready) begin
                  state_q <= ST_TRL;
               end
            end
            ST_TRL: begin
               if (trg_edge) begin
                  pend_q <= 1'b1;
               end
               if (buf_in_ready) begin
                  evt_id_q <= evt_id_q + 12'h001;
                  state_q  <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Two-entry buffer keeps words when the output side stalls
   ttic_skid_buf #(.WIDTH(32)) u_buf (
      .clk      (CLOCK),
      .arst_n   (ARST_N),
      .in_valid (enq_valid),
      .in_ready (buf_in_ready),
      .in_data  (enq_data),
      .out_valid(buf_out_valid),
      .out_ready(WORD_READY || !WORD_VALID),
      .out_data (buf_out_data),
      .full     (buf_full)
   );

   // Registered output stage
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         WORD_VALID <= 1'b0;
         WORD_DATA  <= 32'h0000_0000;
      end else if (WORD_READY || !WORD_VALID) begin
         WORD_VALID <= buf_out_valid;
         WORD_DATA  <= buf_out_data;
      end
   end

   // Configuration window after reset, then indicators follow state
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg_cnt_q            <= CONFIG_CYC;
         acc_cnt_q            <= 3'h0;
         ACCESS_INDICATOR     <= 1'b0;
         FULL_INDICATOR       <= 1'b0;
         ERROR_INDICATOR      <= 1'b0;
         DATA_READY_INDICATOR <= 1'b0;
         TRIGGER_OUT          <= 1'b0;
         CLEAR_OUT            <= 1'b0;
         COUNT_RESET_OUT      <= 1'b0;
      end else begin
         if (configuring) begin
            cfg_cnt_q <= cfg_cnt_q - 32'h0000_0001;
         end
         // Stretch so a single bus cycle is visible on the lamp
         if (REG_SEL) begin
            acc_cnt_q <= 3'h5; // R16
         end else if (acc_cnt_q != 3'h0) begin
            acc_cnt_q <= acc_cnt_q - 3'h1;
         end
         ACCESS_INDICATOR     <= REG_SEL || (acc_cnt_q != 3'h0); // R16
         FULL_INDICATOR       <= configuring || OUTBUF_FULL; // R17 R20
         ERROR_INDICATOR      <= configuring || err_s_q[1]; // R18 R20
         DATA_READY_INDICATOR <= configuring || (EVENT_MODE ? (OUTBUF_EVENTS != 16'h0000)
                                                            : (OUTBUF_WORDS != 16'h0000)); // R19 R20
         TRIGGER_OUT          <= trg_edge;
         CLEAR_OUT            <= clr_s_q[1];
         COUNT_RESET_OUT      <= count_reset_input_edge;
      end
   end
endmodule // ttic_core

// >>> core/ttic_regs.vh
// Register offsets, field positions, reset values and timing counts for the time tag / INL correction block
`ifndef TTIC_REGS_VH
`define TTIC_REGS_VH
`define TTIC_CTRL_OFFSET      16'h1000
`define TTIC_CTRL_RESET       16'h0020
`define TTIC_CTRL_INL_EN_BIT  5
`define TTIC_CTRL_TAG_A_BIT   9
`define TTIC_CTRL_TAG_B_BIT   11
`define TTIC_CTRL_TAG_MASK    16'h0A00
`define TTIC_TAG_HI_MASK      32'h07FF_FFFF
`define TTIC_TAG_LO_MASK      32'h0000_001F
`define TTIC_TAG_WORD_ID      5'h11
`define TTIC_TRAILER_ID       5'h10
`define TTIC_HEADER_ID        5'h08
`define TTIC_RES_800PS        2'h0
`define TTIC_RES_200PS        2'h1
`define TTIC_RES_100PS        2'h2
`define TTIC_LUT200_MASK      8'h7F
`define TTIC_LUT100_MASK      8'hFF
`define TTIC_CLK_PERIOD_PS    20000
`define TTIC_CONFIG_TIME_MS   2
`define TTIC_CONFIG_CYCLES    ((`TTIC_CONFIG_TIME_MS * 1000000000) / `TTIC_CLK_PERIOD_PS)
`define TTIC_LED_STRETCH_NS   100
`define TTIC_LED_STRETCH_CYC  ((`TTIC_LED_STRETCH_NS * 1000) / `TTIC_CLK_PERIOD_PS)
`endif

// >>> core/ttic_inl_lut.v
// INL correction lookup table loaded word by word from flash, with one-cycle registered lookup
module ttic_inl_lut #(
   parameter ENTRIES = 256,
   parameter IDX_W   = 8,
   parameter VAL_W   = 8
) (
   // Clock and reset
   input  wire             clk,
   input  wire             arst_n,
   // Load port from the flash reader
   input  wire             load_we,
   input  wire [IDX_W-1:0] load_idx,
   input  wire [VAL_W-1:0] load_val,
   // Lookup port
   input  wire [IDX_W-1:0] rd_idx,
   output reg  [VAL_W-1:0] rd_val
);
   reg [VAL_W-1:0] table_mem [0:ENTRIES-1];

   // Table write from flash
   always @(posedge clk) begin
      if (load_we) begin
         table_mem[load_idx] <= load_val; // R10
      end
   end

   // Registered read; the table itself holds no reset value
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_val <= {VAL_W{1'b0}};
      end else begin
         rd_val <= table_mem[rd_idx];
      end
   end
endmodule // ttic_inl_lut

// >>> core/ttic_skid_buf.v
// Two-entry buffer with valid/ready on both sides
module ttic_skid_buf #(
   parameter WIDTH = 32
) (
   // Clock and reset
   input  wire             clk,
   input  wire             arst_n,
   // Filling side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Draining side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   // Status
   output wire             full
);
   reg [WIDTH-1:0] slot_q [0:1];
   reg             wr_ptr_q;
   reg             rd_ptr_q;
   reg [1:0]       count_q;
   wire            push = in_valid && in_ready;
   wire            pop  = out_valid && out_ready;

   assign in_ready  = (count_q != 2'h2);
   assign out_valid = (count_q != 2'h0);
   assign out_data  = slot_q[rd_ptr_q];
   assign full      = (count_q == 2'h2);

   // Storage without reset, pointers and count with reset
   always @(posedge clk) begin
      if (push) begin
         slot_q[wr_ptr_q] <= in_data;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (push && !pop) begin
            count_q <= count_q + 2'h1;
         end else if (pop && !push) begin
            count_q <= count_q - 2'h1;
         end
      end
   end
endmodule // ttic_skid_buf

// >>> test/ttic_sva.sv
// Port-level assertions for the time tag and correction block
module ttic_sva #(
   parameter CONFIG_CYC = 8
) (
   // Clock and reset
   input wire        CLOCK,
   input wire        ARST_N,
   // Register port
   input wire        REG_SEL,
   input wire        REG_WR,
   input wire [15:0] REG_ADDR,
   input wire [15:0] REG_RDATA,
   // Triggers and status inputs
   input wire        TRIG_PANEL,
   input wire        TRIG_CONN,
   input wire        GLOBAL_ERROR,
   input wire        EVENT_MODE,
   input wire        OUTBUF_FULL,
   input wire [15:0] OUTBUF_EVENTS,
   input wire [15:0] OUTBUF_WORDS,
   // Word stream
   input wire        WORD_VALID,
   input wire        WORD_READY,
   input wire [31:0] WORD_DATA,
   // Indicators and pulses
   input wire        ACCESS_INDICATOR,
   input wire        FULL_INDICATOR,
   input wire        ERROR_INDICATOR,
   input wire        DATA_READY_INDICATOR,
   input wire        TRIGGER_OUT
);
   reg  [7:0] cyc_q;
   wire [7:0] cyc_d    = (cyc_q == 8'hFF) ? cyc_q : cyc_q + 8'h01;
   wire       cfg_done = cyc_q > CONFIG_CYC + 2;
   wire       want_rdy = EVENT_MODE ? (OUTBUF_EVENTS != 0) : (OUTBUF_WORDS != 0);
   // Edges since reset release; saturates so it never wraps into the start window
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N)
         cyc_q <= 8'h00;
      else
         cyc_q <= cyc_d;
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   a_access_lamp_on: assert property (REG_SEL |-> ##[1:2] ACCESS_INDICATOR)
      else $error("access lamp not lit");
   a_full_lamp_follows: assert property ((cfg_done && $stable(OUTBUF_FULL))[*4] |-> FULL_INDICATOR == OUTBUF_FULL)
      else $error("full lamp wrong");
   a_error_lamp_follows: assert property ((cfg_done && $stable(GLOBAL_ERROR))[*4] |-> ERROR_INDICATOR == GLOBAL_ERROR)
      else $error("error lamp wrong");
   a_ready_lamp_follows: assert property ((cfg_done && $stable(want_rdy))[*4] |-> DATA_READY_INDICATOR == want_rdy)
      else $error("data ready lamp wrong");
   a_config_lamps_lit: assert property (cyc_q >= 1 && cyc_q < CONFIG_CYC |->
      FULL_INDICATOR && ERROR_INDICATOR && DATA_READY_INDICATOR)
      else $error("start lamps not lit");
   a_config_lamps_off: assert property (cyc_q == CONFIG_CYC + 4 |->
      !(FULL_INDICATOR && ERROR_INDICATOR && DATA_READY_INDICATOR))
      else $error("start lamps not released");
   a_trigger_taken: assert property ($rose(TRIG_PANEL || TRIG_CONN) |-> ##[1:4] TRIGGER_OUT)
      else $error("trigger not taken");
   a_trigger_single: assert property (TRIGGER_OUT |=> !TRIGGER_OUT)
      else $error("trigger pulse too long");
   a_unmapped_zero: assert property (REG_SEL && !REG_WR && REG_ADDR != 16'h1000 |=> REG_RDATA == 16'h0000)
      else $error("unmapped read not zero");
   a_word_held: assert property (WORD_VALID && !WORD_READY |=> WORD_VALID && $stable(WORD_DATA))
      else $error("stalled word changed");
endmodule // ttic_sva

// >>> test/ttic_sink.sv
// Output buffer model: takes event words with stalls and reports its fill state
module ttic_sink #(
   parameter FULL_LEVEL = 16
) (
   // Clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // Bench control
   input  wire        stall,
   input  wire        flush,
   // Word stream
   input  wire        word_valid,
   output reg         word_ready,
   input  wire [31:0] word_data,
   // Fill state
   output wire        full,
   output reg  [15:0] events,
   output reg  [15:0] words
);
   assign full = words >= FULL_LEVEL;
   // Random acceptance so the block meets prompt and slow drains alike
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         word_ready <= 1'b0;
         events <= 16'h0000;
         words <= 16'h0000;
      end else begin
         word_ready <= !stall && ($urandom % 4 != 0);
         if (flush) begin
            events <= 16'h0000;
            words <= 16'h0000;
         end else if (word_valid && word_ready) begin
            words <= words + 16'h0001;
            if (word_data[31:27] == 5'h10)
               events <= events + 16'h0001;
         end
      end
   end
endmodule // ttic_sink

// >>> test/ttic_tb.sv
// Self-checking bench for the time tag and correction block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam CONFIG_CYC = 8;
   localparam [4:0] SLOT = 5'h15;
   reg         CLOCK, ARST_N, REG_SEL, REG_WR, TRIG_PANEL, TRIG_CONN, GLOBAL_ERROR, EVENT_MODE;
   reg         FLASH_WE, FLASH_SEL_100PS, HIT_VALID, EVT_END, stall, flush, saw_block, HW_CLR, CNT_RST;
   reg  [15:0] REG_ADDR, REG_WDATA;
   reg  [1:0]  RESOLUTION;
   reg  [7:0]  FLASH_IDX, FLASH_VAL;
   reg  [20:0] HIT_TIME;
   wire [15:0] REG_RDATA, OUTBUF_EVENTS, OUTBUF_WORDS;
   wire        HIT_READY, WORD_VALID, WORD_READY, OUTBUF_FULL, CLEAR_OUT, COUNT_RESET_OUT;
   wire [31:0] WORD_DATA;
   logic [7:0]  lut200 [128];
   logic [7:0]  lut100 [256];
   logic [33:0] expq [$];
   logic [31:0] tag_word, last_tag;
   int          fails = 0, checks_done = 0, cyc = 0, last_trig = 0, have_trig = 0;
   ttic_core #(.CONFIG_CYC(CONFIG_CYC), .SLOT(SLOT)) dut (
      .CLOCK(CLOCK), .ARST_N(ARST_N), .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TRIG_PANEL(TRIG_PANEL), .TRIG_CONN(TRIG_CONN),
      .HARDWARE_CLEAR_INPUT(HW_CLR), .COUNT_RESET_INPUT(CNT_RST), .GLOBAL_ERROR(GLOBAL_ERROR),
      .RESOLUTION(RESOLUTION), .EVENT_MODE(EVENT_MODE), .FLASH_WE(FLASH_WE), .FLASH_SEL_100PS(FLASH_SEL_100PS),
      .FLASH_IDX(FLASH_IDX), .FLASH_VAL(FLASH_VAL), .HIT_VALID(HIT_VALID), .HIT_READY(HIT_READY),
      .HIT_TIME(HIT_TIME), .EVT_END(EVT_END), .WORD_VALID(WORD_VALID), .WORD_READY(WORD_READY),
      .WORD_DATA(WORD_DATA), .OUTBUF_FULL(OUTBUF_FULL), .OUTBUF_EVENTS(OUTBUF_EVENTS), .OUTBUF_WORDS(OUTBUF_WORDS),
      .ACCESS_INDICATOR(), .FULL_INDICATOR(), .ERROR_INDICATOR(), .DATA_READY_INDICATOR(),
      .TRIGGER_OUT(), .CLEAR_OUT(CLEAR_OUT), .COUNT_RESET_OUT(COUNT_RESET_OUT));
   ttic_sink #(.FULL_LEVEL(16)) u_sink (.clk(CLOCK), .arst_n(ARST_N), .stall(stall), .flush(flush),
      .word_valid(WORD_VALID), .word_ready(WORD_READY), .word_data(WORD_DATA),
      .full(OUTBUF_FULL), .events(OUTBUF_EVENTS), .words(OUTBUF_WORDS));
   // Free clock; cycle count by NBA so all readers agree
   initial begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) cyc <= cyc + 1;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude;
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Register cycle: request held over the taking edge and one more edge, then one idle edge
   task automatic reg_acc(input logic wr, input logic [15:0] addr, input logic [15:0] data, input logic [15:0] exp);
      REG_SEL <= 1'b1;
      REG_WR <= wr;
      REG_ADDR <= addr;
      REG_WDATA <= data;
      @(posedge CLOCK);
      #1;
      if (!wr)
         chk("reg_rdata", {16'h0000, exp}, {16'h0000, REG_RDATA});
      @(posedge CLOCK);
      REG_SEL <= 1'b0;
      REG_WR <= 1'b0;
      @(posedge CLOCK);
   endtask
   function automatic logic [31:0] corr(input logic [20:0] raw, input logic [1:0] res, input logic en);
      logic [20:0] v;
      v = raw;
      if (en && res == 2'h1)
         v = raw - {{13{lut200[raw[6:0]][7]}}, lut200[raw[6:0]]};
      if (en && res == 2'h2)
         v = raw - {{13{lut100[raw[7:0]][7]}}, lut100[raw[7:0]]};
      return {11'h000, v};
   endfunction
   // One event: control write, trigger pulse, hits, then the expected closing words
   task automatic run_event(input int j, input int n, input logic [15:0] ctrl);
      logic        tag_on;
      logic [20:0] raw;
      int          d;
      tag_on = (ctrl & 16'h0A00) == 16'h0A00;
      reg_acc(1'b1, 16'h1000, ctrl, 16'h0000);
      RESOLUTION <= j % 3;
      EVENT_MODE <= $urandom;
      d = (tag_on && have_trig) ? cyc - last_trig : 0;
      if (tag_on) begin
         last_trig = cyc;
         have_trig = 1;
      end
      if (j % 2)
         TRIG_PANEL <= 1'b1;
      else
         TRIG_CONN <= 1'b1;
      repeat (2) @(posedge CLOCK);
      TRIG_PANEL <= 1'b0;
      TRIG_CONN <= 1'b0;
      for (int i = 0; i < n; i++) begin
         raw = $urandom;
         HIT_VALID <= 1'b1;
         HIT_TIME <= raw;
         EVT_END <= (i == n - 1);
         expq.push_back({2'd0, corr(raw, RESOLUTION, ctrl[5])});
         do begin
            @(posedge CLOCK);
            if (HIT_READY !== 1'b1)
               saw_block |= stall;
         end while (HIT_READY !== 1'b1);
      end
      HIT_VALID <= 1'b0;
      EVT_END <= 1'b0;
      if (tag_on)
         expq.push_back({2'd1, 32'h0000_0000});
      expq.push_back({tag_on ? 2'd2 : 2'd3, 32'(d)});
      while (expq.size() != 0)
         @(posedge CLOCK);
   endtask
   // Word watcher: every accepted word except a header (ID 08) is matched against the oldest note
   always @(posedge CLOCK) begin : watch
      logic [33:0] e;
      logic [31:0] tag;
      if (WORD_VALID === 1'b1 && WORD_READY === 1'b1 && WORD_DATA[31:27] !== 5'h08) begin
         if (expq.size() == 0)
            chk("word_unexpected", 32'h0000_0000, WORD_DATA);
         else begin
            e = expq.pop_front();
            if (e[33:32] >= 2'd2)
               chk("trailer_id", 32'h0000_0010, WORD_DATA[31:27]);
            case (e[33:32])
               2'd0: chk("hit_word", e[31:0], WORD_DATA);
               2'd1: begin
                  chk("tag_id", 32'h0000_0011, WORD_DATA[31:27]);
                  tag_word = WORD_DATA;
               end
               2'd2: begin
                  tag = {tag_word[26:0], WORD_DATA[26:22]};
                  if (e[31:0] != 0)
                     chk("tag_delta", e[31:0], tag - last_tag);
                  last_tag = tag;
               end
               default: chk("trailer_slot", SLOT, WORD_DATA[26:22]);
            endcase
         end
      end
   end
   // Watchdog sized well past the longest expected run
   initial begin
      repeat (30000) @(posedge CLOCK);
      fails++;
      conclude();
   end
   initial begin : main
      logic [7:0] v;
      logic [15:0] ctrls [4] = '{16'h0A20, 16'h0A00, 16'h0220, 16'h0820};
      {ARST_N, REG_SEL, REG_WR, TRIG_PANEL, TRIG_CONN, GLOBAL_ERROR, EVENT_MODE} = 7'h00;
      {FLASH_WE, FLASH_SEL_100PS, HIT_VALID, EVT_END, stall, flush, saw_block, HW_CLR, CNT_RST} = 9'h000;
      {REG_ADDR, REG_WDATA, RESOLUTION, FLASH_IDX, FLASH_VAL, HIT_TIME} = 71'h0;
      void'($urandom(90001));
      repeat (10) @(posedge CLOCK);
      ARST_N <= 1'b1;
      repeat (CONFIG_CYC + 8) @(posedge CLOCK);
      reg_acc(1'b0, 16'h1000, 16'h0000, 16'h0020);
      reg_acc(1'b1, 16'h1002, 16'hFFFF, 16'h0000);
      reg_acc(1'b0, 16'h1002, 16'h0000, 16'h0000);
      reg_acc(1'b0, 16'h1000, 16'h0000, 16'h0020);
      for (int i = 0; i < 384; i++) begin
         v = $urandom;
         if (i < 128)
            lut200[i] = v;
         else
            lut100[i - 128] = v;
         FLASH_WE <= 1'b1;
         FLASH_SEL_100PS <= (i >= 128);
         FLASH_IDX <= (i < 128) ? i : i - 128;
         FLASH_VAL <= v;
         @(posedge CLOCK);
      end
      FLASH_WE <= 1'b0;
      for (int j = 0; j < 12; j++) begin
         if (j == 5)
            fork
               begin
                  stall <= 1'b1;
                  repeat (60) @(posedge CLOCK);
                  stall <= 1'b0;
               end
            join_none
         run_event(j, (j == 5) ? 10 : 1 + $urandom % 4, ctrls[j % 4]);
      end
      chk("hit_refused", 32'h0000_0001, saw_block);
      {GLOBAL_ERROR, HW_CLR, CNT_RST} <= 3'h7;
      repeat (3) @(posedge CLOCK);
      #1 chk("clear_cnt_out", 32'h0000_0003, {30'h0000_0000, CLEAR_OUT, COUNT_RESET_OUT});
      repeat (5) @(posedge CLOCK);
      {GLOBAL_ERROR, HW_CLR, CNT_RST} <= 3'h0;
      flush <= 1'b1;
      @(posedge CLOCK);
      flush <= 1'b0;
      repeat (8) @(posedge CLOCK);
      conclude();
   end
endmodule // testbench
bind ttic_core ttic_sva #(.CONFIG_CYC(CONFIG_CYC)) u_sva (
   .CLOCK(CLOCK), .ARST_N(ARST_N), .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
   .REG_RDATA(REG_RDATA), .TRIG_PANEL(TRIG_PANEL), .TRIG_CONN(TRIG_CONN), .GLOBAL_ERROR(GLOBAL_ERROR),
   .EVENT_MODE(EVENT_MODE), .OUTBUF_FULL(OUTBUF_FULL), .OUTBUF_EVENTS(OUTBUF_EVENTS), .OUTBUF_WORDS(OUTBUF_WORDS),
   .WORD_VALID(WORD_VALID), .WORD_READY(WORD_READY), .WORD_DATA(WORD_DATA), .ACCESS_INDICATOR(ACCESS_INDICATOR),
   .FULL_INDICATOR(FULL_INDICATOR), .ERROR_INDICATOR(ERROR_INDICATOR),
   .DATA_READY_INDICATOR(DATA_READY_INDICATOR), .TRIGGER_OUT(TRIGGER_OUT));
